// ### rtl/ihs_defines.vh
// Constants for the internal homing sequencer.
// Assumes a 40 MHz clock; included by the sequencer and its timer.
`ifndef IHS_DEFINES_VH
`define IHS_DEFINES_VH
`define IHS_CLK_HZ 40000000
`define IHS_CYC_PER_MS (`IHS_CLK_HZ / 1000)
`define IHS_METHOD_RLIM 8'h01
`define IHS_METHOD_FLIM 8'h02
`define IHS_METHOD_LEFT 8'h07
`define IHS_METHOD_RIGHT 8'h08
`define IHS_TIME_LIMIT_S_RST 8'h32
`define IHS_DECEL_MS_RST 16'h000A
`define IHS_DIR_POS 1'b0
`define IHS_DIR_NEG 1'b1
`define IHS_SYNC_W 3
`endif

// ### rtl/ihs_timer.v
// Down counter of whole units, each unit a fixed number of clock cycles.
// Assumes load and clear come from logic on the same clock.
`timescale 1ns/100ps
`include "ihs_defines.vh"
module ihs_timer #(
    parameter CNT_W = 16,
    parameter UNIT_CYC = 40000
) (
    input wire clk,
    input wire reset,
    input wire load,
    input wire clear,
    input wire [CNT_W-1:0] units,
    output wire expired
);
    reg [CNT_W-1:0] units_ff;
    reg [31:0] cyc_ff;
    reg run_ff;
    assign expired = run_ff && (units_ff == {CNT_W{1'b0}});
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            units_ff <= {CNT_W{1'b0}};
            cyc_ff <= 32'h00000000;
            run_ff <= 1'b0;
        end else if (load) begin
            // Wins over clear, which is still high in the start cycle
            units_ff <= units;
            cyc_ff <= UNIT_CYC - 1;
            run_ff <= 1'b1;
        end else if (clear) begin
            run_ff <= 1'b0;
        end else if (run_ff && units_ff != {CNT_W{1'b0}}) begin
            if (cyc_ff == 32'h00000000) begin
                cyc_ff <= UNIT_CYC - 1;
                units_ff <= units_ff - 1'b1;
            end else begin
                cyc_ff <= cyc_ff - 32'h00000001;
            end
        end
    end
endmodule

// ### rtl/ihs_sequencer.v
// Internal homing sequencer: searches limits, sensor edges and index.
// Assumes pin inputs are asynchronous; motion profile lies outside.
// How it works
// - Detection triggers stop with emergency decel time
// - Next signal ignored until motor stopped
// - Method 1: fast negative to reverse limit
// - Method 1: then slow positive to index
// - Method 2: fast positive to forward limit
// - Method 2: then slow negative to index
// - Methods 7/8 outside: fast positive, rising edge
// - Methods 7/8 inside: fast negative, falling edge
// - Method 7: then slow negative to index
// - Method 8: then slow positive to index
// - Over time limit aborts, reports failure
// - Homing allowed only in position modes
// - Index loads offset, optionally moves to zero
`timescale 1ns/100ps
`include "ihs_defines.vh"
module ihs_sequencer #(
    parameter VEL_W = 12,
    parameter POS_W = 32,
    parameter CYC_PER_S = 40000000,
    parameter CYC_PER_MS = 40000
) (
    input wire clk,
    input wire reset,
    input wire start,
    input wire position_mode,
    input wire [7:0] homing_method_select,
    input wire [VEL_W-1:0] fast_search_velocity,
    input wire [VEL_W-1:0] slow_search_velocity,
    input wire [7:0] homing_time_limit,
    input wire [POS_W-1:0] home_offset_value,
    input wire [15:0] homing_emergency_decel_time,
    input wire move_to_zero_en,
    input wire reverse_limit_input,
    input wire forward_limit_input,
    input wire near_home_sensor_input,
    input wire index_input,
    input wire motor_stopped,
    input wire move_zero_done,
    output reg motion_run,
    output reg motion_dir,
    output reg [VEL_W-1:0] motion_velocity,
    output reg stop_req,
    output reg [15:0] stop_decel_time,
    output reg pos_load,
    output reg [POS_W-1:0] pos_load_value,
    output reg move_zero_req,
    output reg busy,
    output reg done,
    output reg fail,
    output reg rejected
);
    localparam S_IDLE = 7'b0000001;
    localparam S_FAST = 7'b0000010;
    localparam S_STOP1 = 7'b0000100;
    localparam S_SLOW = 7'b0001000;
    localparam S_STOP2 = 7'b0010000;
    localparam S_ZERO = 7'b0100000;
    localparam S_ABORT = 7'b1000000;

    // Pins: three stages, change once stages two and three agree
    reg [`IHS_SYNC_W-1:0] rlim_sy_ff, flim_sy_ff, dog_sy_ff, idx_sy_ff;
    reg rlim_ff, flim_ff, dog_ff, idx_ff, dog_prev_ff;
    reg [6:0] state_ff;
    reg [7:0] method_ff;
    reg inside_ff;
    reg [6:0] nxt_state;
    wire dog_rise = dog_ff && !dog_prev_ff;
    wire dog_fall = !dog_ff && dog_prev_ff;
    wire method_ok = homing_method_select == `IHS_METHOD_RLIM ||
        homing_method_select == `IHS_METHOD_FLIM ||
        homing_method_select == `IHS_METHOD_LEFT ||
        homing_method_select == `IHS_METHOD_RIGHT;
    wire limit_run;
    reg timer_load;

    function agreed;
        input [`IHS_SYNC_W-1:0] sy;
        input old;
        agreed = (sy[2] == sy[1]) ? sy[1] : old;
    endfunction

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rlim_sy_ff <= 3'h0;
            flim_sy_ff <= 3'h0;
            dog_sy_ff <= 3'h0;
            idx_sy_ff <= 3'h0;
            rlim_ff <= 1'b0;
            flim_ff <= 1'b0;
            dog_ff <= 1'b0;
            idx_ff <= 1'b0;
            dog_prev_ff <= 1'b0;
        end else begin
            rlim_sy_ff <= {rlim_sy_ff[1:0], reverse_limit_input};
            flim_sy_ff <= {flim_sy_ff[1:0], forward_limit_input};
            dog_sy_ff <= {dog_sy_ff[1:0], near_home_sensor_input};
            idx_sy_ff <= {idx_sy_ff[1:0], index_input};
            rlim_ff <= agreed(rlim_sy_ff, rlim_ff);
            flim_ff <= agreed(flim_sy_ff, flim_ff);
            dog_ff <= agreed(dog_sy_ff, dog_ff);
            idx_ff <= agreed(idx_sy_ff, idx_ff);
            dog_prev_ff <= dog_ff;
        end
    end

    // Time limit in seconds; zero gives an immediate failure
    ihs_timer #(
        .CNT_W(8),
        .UNIT_CYC(CYC_PER_S)
    ) u_limit (
        .clk(clk),
        .reset(reset),
        .load(timer_load),
        .clear(state_ff == S_IDLE),
        .units(homing_time_limit),
        .expired(limit_run)
    );

    // Search is detected only while moving; stop states ignore pins
    wire fast_hit = (method_ff == `IHS_METHOD_RLIM) ? rlim_ff :
        (method_ff == `IHS_METHOD_FLIM) ? flim_ff :
        (inside_ff ? dog_fall : dog_rise);

    always @* begin
        nxt_state = state_ff;
        timer_load = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (start && position_mode && method_ok) begin
                    nxt_state = S_FAST;
                    timer_load = 1'b1;
                end
            end
            S_FAST: if (fast_hit) nxt_state = S_STOP1;
            S_STOP1: if (motor_stopped) nxt_state = S_SLOW;
            S_SLOW: if (idx_ff) nxt_state = S_STOP2;
            S_STOP2: if (motor_stopped) nxt_state = move_to_zero_en ? S_ZERO : S_IDLE;
            S_ZERO: if (move_zero_done) nxt_state = S_IDLE;
            S_ABORT: if (motor_stopped) nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
        if (limit_run && state_ff != S_IDLE && state_ff != S_ABORT)
            nxt_state = S_ABORT;
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= S_IDLE;
            method_ff <= 8'h00;
            inside_ff <= 1'b0;
            motion_run <= 1'b0;
            motion_dir <= `IHS_DIR_POS;
            motion_velocity <= {VEL_W{1'b0}};
            stop_req <= 1'b0;
            stop_decel_time <= `IHS_DECEL_MS_RST;
            pos_load <= 1'b0;
            pos_load_value <= {POS_W{1'b0}};
            move_zero_req <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            rejected <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pos_load <= 1'b0;
            rejected <= 1'b0;
            if (state_ff == S_IDLE && start) begin
                rejected <= !(position_mode && method_ok);
                if (position_mode && method_ok) begin
                    method_ff <= homing_method_select;
                    inside_ff <= dog_ff;
                    done <= 1'b0;
                    fail <= 1'b0;
                end
            end
            busy <= nxt_state != S_IDLE;
            motion_run <= nxt_state == S_FAST || nxt_state == S_SLOW;
            stop_req <= nxt_state == S_STOP1 || nxt_state == S_STOP2 ||
                nxt_state == S_ABORT;
            stop_decel_time <= homing_emergency_decel_time;
            move_zero_req <= nxt_state == S_ZERO;
            if (nxt_state == S_FAST) begin
                motion_velocity <= fast_search_velocity;
                if (state_ff == S_IDLE) begin
                    if (homing_method_select == `IHS_METHOD_RLIM)
                        motion_dir <= `IHS_DIR_NEG;
                    else if (homing_method_select == `IHS_METHOD_FLIM)
                        motion_dir <= `IHS_DIR_POS;
                    else
                        motion_dir <= dog_ff ? `IHS_DIR_NEG : `IHS_DIR_POS;
                end
            end
            if (nxt_state == S_SLOW && state_ff == S_STOP1) begin
                motion_velocity <= slow_search_velocity;
                motion_dir <= (method_ff == `IHS_METHOD_FLIM ||
                    method_ff == `IHS_METHOD_LEFT) ? `IHS_DIR_NEG : `IHS_DIR_POS;
            end
            if (state_ff == S_SLOW && nxt_state == S_STOP2) begin
                pos_load <= 1'b1;
                pos_load_value <= home_offset_value;
            end
            if (state_ff != S_IDLE && nxt_state == S_IDLE && state_ff != S_ABORT)
                done <= 1'b1;
            if (nxt_state == S_ABORT)
                fail <= 1'b1;
        end
    end
endmodule

// ### dv/ihs_seq_chk.sv
// Port assertions for the homing sequencer.
// Assumes settings and pins are held steady while a run is busy.
`timescale 1ns/100ps
module ihs_seq_chk #(
    parameter VEL_W = 12,
    parameter POS_W = 32
) (
    input wire clk,
    input wire reset,
    input wire position_mode,
    input wire [7:0] homing_method_select,
    input wire [VEL_W-1:0] fast_search_velocity,
    input wire [VEL_W-1:0] slow_search_velocity,
    input wire [7:0] homing_time_limit,
    input wire [POS_W-1:0] home_offset_value,
    input wire [15:0] homing_emergency_decel_time,
    input wire move_to_zero_en,
    input wire near_home_sensor_input,
    input wire motor_stopped,
    input wire motion_run,
    input wire motion_dir,
    input wire [VEL_W-1:0] motion_velocity,
    input wire stop_req,
    input wire [15:0] stop_decel_time,
    input wire pos_load,
    input wire [POS_W-1:0] pos_load_value,
    input wire move_zero_req,
    input wire busy,
    input wire done,
    input wire fail,
    input wire rejected
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire [7:0] m = homing_method_select;
    mode_gate_a: assert property ($rose(busy) |-> $past(position_mode))
        else $error("run accepted outside position mode");
    fast_start_a: assert property ($rose(busy) |-> motion_run &&
        motion_velocity == fast_search_velocity && motion_dir ==
        (m == 8'h01 ? 1'b1 : m == 8'h02 ? 1'b0 : near_home_sensor_input))
        else $error("wrong first search");
    slow_run_a: assert property ($rose(motion_run) && !$rose(busy) |->
        motion_velocity == slow_search_velocity && motion_dir == !(m == 8'h01 || m == 8'h08))
        else $error("wrong slow search");
    halt_decel_a: assert property ($fell(motion_run) |-> stop_req &&
        stop_decel_time == homing_emergency_decel_time) else $error("no stop on detection");
    wait_stop_a: assert property (stop_req && !motor_stopped |=>
        !motion_run && !done && !move_zero_req) else $error("moved before standstill");
    load_pulse_a: assert property (pos_load |-> stop_req &&
        pos_load_value == home_offset_value ##1 !pos_load) else $error("bad position load");
    zero_opt_a: assert property ($rose(move_zero_req) |-> move_to_zero_en)
        else $error("zero move without option");
    reject_pulse_a: assert property (rejected |-> !busy ##1 !rejected)
        else $error("bad refusal pulse");
    zero_limit_a: assert property ($rose(busy) && homing_time_limit == 8'h00 |->
        ##[1:8] fail) else $error("zero limit did not fail");
    fail_excl_a: assert property (fail |-> !done)
        else $error("fail and done together");
    cover property ($rose(done));
    cover property ($rose(fail));
    cover property (rejected);
    cover property ($rose(move_zero_req));
endmodule

// ### dv/ihs_motion_model.sv
// Motor, limits, near-home sensor and index as position windows.
// Assumes one step a cycle while the run command is high.
`timescale 1ns/100ps
module ihs_motion_model (
    input wire clk,
    input wire reset,
    input wire motion_run,
    input wire motion_dir,
    input wire move_zero_req,
    input wire load,
    input wire signed [15:0] load_pos,
    input wire [7:0] stop_dly,
    output wire reverse_limit_input,
    output wire forward_limit_input,
    output wire near_home_sensor_input,
    output wire index_input,
    output wire motor_stopped,
    output reg move_zero_done
);
    reg signed [15:0] pos_ff;
    reg [7:0] still_ff;
    assign reverse_limit_input = pos_ff <= -16'sd200;
    assign forward_limit_input = pos_ff >= 16'sd300;
    assign near_home_sensor_input = pos_ff >= 16'sd100 && pos_ff < 16'sd200;
    // Index three steps wide so the input filter cannot miss it
    assign index_input = pos_ff[4:0] >= 5'h08 && pos_ff[4:0] <= 5'h0A;
    // standstill stands for completion width reached
    assign motor_stopped = !motion_run && still_ff >= stop_dly;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_ff <= 16'sd0;
            still_ff <= 8'h00;
            move_zero_done <= 1'b0;
        end else begin
            if (load)
                pos_ff <= load_pos;
            else if (motion_run)
                pos_ff <= motion_dir ? pos_ff - 16'sd1 : pos_ff + 16'sd1;
            still_ff <= motion_run ? 8'h00 : still_ff + {7'h00, still_ff != 8'hFF};
            move_zero_done <= move_zero_req;
        end
    end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the homing sequencer with a motion model.
// Assumes a shortened second so time limits stay within the run.
`timescale 1ns/100ps
module tb_top;
    reg clk = 0, reset = 1, start = 0, position_mode = 1, move_to_zero_en = 0, load = 0;
    reg [7:0] homing_method_select = 8'h01, homing_time_limit = 8'h05, stop_dly = 8'h00;
    reg [11:0] fast_search_velocity = 12'h000, slow_search_velocity = 12'h000;
    reg [31:0] home_offset_value = 32'h0;
    reg [15:0] homing_emergency_decel_time = 16'h000A;
    reg signed [15:0] load_pos = 16'sd0;
    wire reverse_limit_input, forward_limit_input, near_home_sensor_input, index_input;
    wire motor_stopped, move_zero_done, motion_run, motion_dir, stop_req, pos_load;
    wire move_zero_req, busy, done, fail, rejected;
    wire [11:0] motion_velocity;
    wire [15:0] stop_decel_time;
    wire [31:0] pos_load_value;
    integer bad_count = 0, cmp_count = 0, i, k;
    reg rej_seen, load_seen, zero_seen;
    reg [31:0] ofs_seen;
    reg [1:0] pd;
    always #12.5 clk = ~clk;
    ihs_sequencer #(.CYC_PER_S(4000)) u_dut (.*);
    ihs_motion_model u_model (.*);
    task check(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %0t: seen %h expected %h", $time, got, exp);
            end
        end
    endtask
    function [3:0] expect_flags(input [7:0] m, input [7:0] lim, input pm, input [1:0] p);
        reg acc;
        begin
            acc = pm && (m == 8'h01 || m == 8'h02 || m == 8'h07 || m == 8'h08);
            expect_flags = acc ? {lim != 8'h00, lim == 8'h00, 1'b0, lim != 8'h00} : {p, 2'b10};
        end
    endfunction
    task test_done;
        begin
            $display("compares %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task home(input [7:0] m, input integer p, input [7:0] lim, input pm);
        begin
            @(posedge clk);
            homing_method_select <= m;
            homing_time_limit <= lim;
            position_mode <= pm;
            load_pos <= p[15:0];
            load <= 1'b1;
            fast_search_velocity <= 12'($urandom % 3001);
            slow_search_velocity <= 12'($urandom % 3001);
            home_offset_value <= $urandom;
            homing_emergency_decel_time <= 16'(2 + $urandom % 999);
            move_to_zero_en <= 1'($urandom % 2);
            stop_dly <= 8'($urandom % 40);
            @(posedge clk);
            load <= 1'b0;
            repeat (8) @(posedge clk);
            pd = {done, fail};
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            rej_seen = 0;
            load_seen = 0;
            zero_seen = 0;
            ofs_seen = 32'h00000000;
            k = 0;
            while (!rej_seen && !(k > 2 && !busy) && k < 20000) begin
                @(posedge clk);
                k = k + 1;
                rej_seen = rej_seen | rejected;
                load_seen = load_seen | pos_load;
                zero_seen = zero_seen | move_zero_req;
                if (pos_load)
                    ofs_seen = pos_load_value;
            end
            if (k == 20000) begin
                bad_count = bad_count + 1;
                $display("ERROR %0t: homing run did not finish", $time);
                test_done;
            end else begin
                check({done, fail, rej_seen, load_seen}, expect_flags(m, lim, pm, pd));
                check(ofs_seen, load_seen ? home_offset_value : 32'h00000000);
                check(zero_seen, expect_flags(m, lim, pm, pd) == 4'h9 && move_to_zero_en);
            end
        end
    endtask
    initial begin
        k = $urandom(32'h29CD);
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 16; i = i + 1) begin
            if (i % 4 < 2)
                home(8'(i % 4 + 1), $urandom % 400 - 150, 8'h05, 1'b1);
            else if (i % 8 < 4)
                home(8'(i % 4 + 5), $urandom % 250 - 150, 8'h05, 1'b1);
            else
                home(8'(i % 4 + 5), $urandom % 100 + 100, 8'h05, 1'b1);
        end
        // Refusals: wrong mode, unsupported codes, then a zero time limit that fails, then a method 8 run from inside the sensor
        home(8'h01, 0, 8'h05, 1'b0);
        home(8'h03, 0, 8'h05, 1'b1);
        home(8'h09, 0, 8'h05, 1'b1);
        home(8'h02, 0, 8'h00, 1'b1);
        home(8'h08, 150, 8'h64, 1'b1);
        test_done;
    end
endmodule
bind ihs_sequencer ihs_seq_chk #(.VEL_W(VEL_W), .POS_W(POS_W)) u_chk (.*);
